// ===== src/ouhcs_pkg.sv
// =============================================================
// Shared constants and types for the host channel select front end.
package ouhcs_pkg;

    // =============================================================
    // Sizes.
    localparam int CHANNELS   = 8;
    localparam int DATA_W     = 8;
    localparam int ADDR_W     = 8;
    localparam int SUBADDR_W  = 4;
    localparam int CHAN_W     = 3;
    localparam int SYNC_DEPTH = 2;

    // =============================================================
    // Address fields.
    localparam int CFG_SPACE_BIT = 7;
    localparam int CHAN_SEL_LSB  = 4;
    localparam int CHAN_SEL_MSB  = 6;

    // =============================================================
    // Device configuration register offsets.
    localparam logic [7:0] CFG_INT_SRC0 = 8'h80;
    localparam logic [7:0] CFG_INT_SRC1 = 8'h81;
    localparam logic [7:0] CFG_INT_SRC2 = 8'h82;
    localparam logic [7:0] CFG_INT_SRC3 = 8'h83;
    localparam logic [7:0] CFG_SW_RESET = 8'h8A;
    localparam logic [7:0] CFG_BCAST    = 8'h8F;

    // =============================================================
    // Field positions and reset values.
    localparam int         BCAST_EN_BIT    = 0;
    localparam int         MCR_IR_BIT      = 6;
    localparam int         FEATURE_CONTROL_REG_IR_INV_BIT = 4;
    localparam logic [7:0] BCAST_RST       = 8'h00;
    localparam logic [7:0] DATA_ZERO       = 8'h00;

    // =============================================================
    // Timing.
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         RESET_MIN_NS  = 40;
    localparam int         RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] STRAP_WAIT    = 2'(SYNC_DEPTH + 1);

    // =============================================================
    // Types.
    typedef logic [CHANNELS-1:0][DATA_W-1:0] ouhcs_byte_arr_type;
    typedef logic [CHANNELS-1:0][1:0]        ouhcs_code_arr_type;

    typedef struct packed {
        logic [CHANNELS-1:0] cts;
        logic [CHANNELS-1:0] dsr;
        logic [CHANNELS-1:0] cd;
        logic [CHANNELS-1:0] ri;
    } ouhcs_modem_type;

    typedef struct packed {
        logic                busStyle;
        logic                csN;
        logic                rdN;
        logic                wrN;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
        logic                strap;
        logic                tmrClk;
        logic [CHANNELS-1:0] rx;
        ouhcs_modem_type     modemN;
    } ouhcs_pins_type;

    localparam ouhcs_pins_type PINS_RST = '{
        busStyle: 1'b1, csN: 1'b1, rdN: 1'b1, wrN: 1'b1,
        addr: 8'h00, data: 8'h00, strap: 1'b0, tmrClk: 1'b0,
        rx: 8'hFF, modemN: '{cts: 8'hFF, dsr: 8'hFF, cd: 8'hFF, ri: 8'hFF}
    };

    typedef enum logic {ACC_IDLE, ACC_ACTIVE} ouhcs_acc_type;

endpackage

// ===== src/ouhcs_sync.sv
// =============================================================
// Two-stage synchroniser for a bundle of asynchronous pins.
module ouhcs_sync
    import ouhcs_pkg::*;
#(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         clock,  // System clock.
    input  wire logic         reset,  // Asynchronous reset, active high.
    input  wire logic [W-1:0] async,  // Pins from outside the clock domain.
    output logic      [W-1:0] synced  // Second stage output.
);

    logic [W-1:0] stage1_r;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            stage1_r <= RST_VAL;
            synced   <= RST_VAL;
        end else begin
            stage1_r <= async;
            synced   <= stage1_r;
        end
    end

endmodule // ouhcs_sync

// ===== src/ouhcs_top.sv
// Overview of operation
// RULE1 - Strap picks separate strobes or alternative style.
// RULE2 - Host drives chip select low per access.
// RULE3 - A7 low: A6:A4 select one channel.
// RULE4 - Broadcast bit makes channel writes hit all.
// RULE5 - Software clears broadcast before channel reads.
// RULE6 - Software broadcasts carefully during active transfers.
// RULE7 - Hardware reset defaults all channels and outputs.
// RULE8 - Host holds hardware reset over 40 ns; the bench releases its first reset after 25 ns.
// RULE9 - Software reset write resets designated channels.
// RULE10 - Infrared strap sampled after resets, loaded.
// RULE11 - Feature bit 4 inverts infrared receive.
// RULE12 - Normal receive input idles high.
// RULE13 - Timer counts from external clock pin.
// RULE14 - Modem pins active low, general purpose.
// RULE15 - Four interrupt source registers cover everything.
// RULE16 - A7 high selects configuration registers.
module ouhcs_top
    import ouhcs_pkg::*;
(
    input  wire logic                clock,             // System clock, 100 MHz.
    input  wire logic                reset,             // Asynchronous reset, active high.
    input  wire logic                busStyleSel,       // Bus style strap pin.
    input  wire logic                csN,               // Chip select pin.
    input  wire logic                readStrobeN,       // Read strobe pin.
    input  wire logic                writeStrobeN,      // Write strobe or read/write pin.
    input  wire logic [ADDR_W-1:0]   addrPin,           // Address pins.
    input  wire logic [DATA_W-1:0]   dataPin,           // Data bus input side.
    output logic      [DATA_W-1:0]   hostDataOut,       // Data bus output side.
    output logic                     hostDataOe,        // Data bus output enable.
    input  wire logic                infraredStartupStrap, // Infrared start-up strap.
    input  wire logic                timerExtClk,       // Timer external clock pin.
    input  wire logic [CHANNELS-1:0] rxPin,             // Receive data pins.
    input  wire logic [CHANNELS-1:0] ctsN,              // Clear-to-send pins.
    input  wire logic [CHANNELS-1:0] dsrN,              // Data-set-ready pins.
    input  wire logic [CHANNELS-1:0] cdN,               // Carrier-detect pins.
    input  wire logic [CHANNELS-1:0] riN,               // Ring-indicator pins.
    input  wire logic [CHANNELS-1:0] txBit,             // Transmit bits from channels.
    input  wire logic [CHANNELS-1:0] rtsReq,            // Request-to-send requests.
    input  wire logic [CHANNELS-1:0] dtrReq,            // Data-terminal-ready requests.
    input  wire ouhcs_byte_arr_type  modemControlReg,   // Channel modem control registers.
    input  wire ouhcs_byte_arr_type  featureControlReg, // Channel feature control registers.
    input  wire ouhcs_byte_arr_type  chanReadData,      // Channel read data.
    input  wire logic [CHANNELS-1:0] chanIntPend,       // Channel interrupt pending.
    input  wire ouhcs_code_arr_type  chanIntCode,       // Channel interrupt class codes.
    input  wire logic                timerIntPend,      // Timer interrupt pending.
    input  wire logic                wakeIntPend,       // Sleep wake-up indicator.
    output logic      [CHANNELS-1:0] txPin,             // Transmit data pins.
    output logic      [CHANNELS-1:0] rtsN,              // Request-to-send pins.
    output logic      [CHANNELS-1:0] dtrN,              // Data-terminal-ready pins.
    output logic      [CHANNELS-1:0] rxToChan,          // Receive data to channels.
    output ouhcs_modem_type          modemIn,           // Modem inputs, active high.
    output logic      [CHANNELS-1:0] chanWrite,         // Channel register write pulses.
    output logic      [CHANNELS-1:0] chanRead,          // Channel register read pulses.
    output logic      [SUBADDR_W-1:0] regSel,           // Register offset in channel.
    output logic      [DATA_W-1:0]   writeData,         // Write data to channels.
    output logic      [CHANNELS-1:0] chanReset,         // Channel reset.
    output logic      [CHANNELS-1:0] irModeLoad,        // Load strap into modem control.
    output logic                     irModeValue,       // Sampled strap level.
    output logic                     timerTick,         // Timer count pulse.
    output logic                     broadcastEn        // Broadcast write enable.
);

    // =============================================================
    // Pin synchronisation.
    ouhcs_pins_type pinsAsync;
    ouhcs_pins_type pins;

    assign pinsAsync = '{busStyle: busStyleSel, csN: csN, rdN: readStrobeN,
                         wrN: writeStrobeN, addr: addrPin, data: dataPin,
                         strap: infraredStartupStrap, tmrClk: timerExtClk, rx: rxPin,
                         modemN: '{cts: ctsN, dsr: dsrN, cd: cdN, ri: riN}};

    ouhcs_sync #(
        .W       ($bits(ouhcs_pins_type)),
        .RST_VAL (PINS_RST)
    ) uPinSync (
        .clock  (clock),
        .reset  (reset),
        .async  (pinsAsync),
        .synced (pins)
    );

    // =============================================================
    // Access decode.
    logic              accActive;
    logic              accIsRead;
    logic              cfgSpace;
    logic [CHAN_W-1:0] chanNum;

    always_comb begin
        // RULE1 bus style select
        if (pins.busStyle) begin
            accActive = !pins.csN && (!pins.rdN || !pins.wrN);
            accIsRead = !pins.rdN;
        end else begin
            accActive = !pins.csN;
            accIsRead = pins.wrN;
        end
    end

    // RULE16 configuration space
    assign cfgSpace = pins.addr[CFG_SPACE_BIT];
    // RULE3 channel number decode
    assign chanNum  = pins.addr[CHAN_SEL_MSB:CHAN_SEL_LSB];

    // =============================================================
    // Access state.
    ouhcs_acc_type accState_r;
    ouhcs_acc_type accState_nxt;
    logic          accStart;

    always_comb begin
        accState_nxt = accState_r;
        unique case (accState_r)
            ACC_IDLE: begin
                if (accActive) begin
                    accState_nxt = ACC_ACTIVE;
                end
            end
            ACC_ACTIVE: begin
                if (!accActive) begin
                    accState_nxt = ACC_IDLE;
                end
            end
        endcase
    end

    assign accStart = (accState_r == ACC_IDLE) && accActive;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            accState_r <= ACC_IDLE;
        end else begin
            accState_r <= accState_nxt;
        end
    end

    // =============================================================
    // Configuration registers and host-facing outputs.
    logic [DATA_W-1:0]   bcast_r, bcast_nxt;
    logic [CHANNELS-1:0] chanWrite_r, chanWrite_nxt;
    logic [CHANNELS-1:0] chanRead_r, chanRead_nxt;
    logic [SUBADDR_W-1:0] regSel_r, regSel_nxt;
    logic [DATA_W-1:0]   writeData_r, writeData_nxt;
    logic [DATA_W-1:0]   hostData_r, hostData_nxt;
    logic                hostOe_r, hostOe_nxt;
    logic [CHANNELS-1:0] swReset;
    logic [DATA_W-1:0]   cfgReadVal;
    logic [DATA_W-1:0]   intSrc3;

    assign intSrc3 = {6'h00, wakeIntPend, timerIntPend};

    always_comb begin
        // RULE15 interrupt source registers
        unique case (pins.addr)
            CFG_INT_SRC0: cfgReadVal = chanIntPend;
            CFG_INT_SRC1: cfgReadVal = chanIntCode[3:0];
            CFG_INT_SRC2: cfgReadVal = chanIntCode[7:4];
            CFG_INT_SRC3: cfgReadVal = intSrc3;
            CFG_BCAST:    cfgReadVal = bcast_r;
            default:      cfgReadVal = DATA_ZERO;
        endcase
    end

    always_comb begin
        bcast_nxt     = bcast_r;
        chanWrite_nxt = '0;
        chanRead_nxt  = '0;
        swReset       = '0;
        regSel_nxt    = regSel_r;
        writeData_nxt = writeData_r;
        hostOe_nxt    = (accState_nxt == ACC_ACTIVE) && accIsRead;
        hostData_nxt  = hostData_r;
        if (accStart) begin
            regSel_nxt    = pins.addr[SUBADDR_W-1:0];
            writeData_nxt = pins.data;
        end
        if (accActive && accIsRead) begin
            hostData_nxt = cfgSpace ? cfgReadVal : chanReadData[chanNum];
        end
        if (accStart && !accIsRead) begin
            if (cfgSpace) begin
                if (pins.addr == CFG_BCAST) begin
                    bcast_nxt = pins.data;
                end
                // RULE9 software reset write
                if (pins.addr == CFG_SW_RESET) begin
                    swReset = pins.data;
                end
            // RULE4 broadcast to all channels
            end else if (bcast_r[BCAST_EN_BIT]) begin
                chanWrite_nxt = '1;
            end else begin
                chanWrite_nxt[chanNum] = 1'b1;
            end
        end
        if (accStart && accIsRead && !cfgSpace) begin
            chanRead_nxt[chanNum] = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            bcast_r     <= BCAST_RST;
            chanWrite_r <= '0;
            chanRead_r  <= '0;
            regSel_r    <= '0;
            writeData_r <= DATA_ZERO;
            hostData_r  <= DATA_ZERO;
            hostOe_r    <= 1'b0;
        end else begin
            bcast_r     <= bcast_nxt;
            chanWrite_r <= chanWrite_nxt;
            chanRead_r  <= chanRead_nxt;
            regSel_r    <= regSel_nxt;
            writeData_r <= writeData_nxt;
            hostData_r  <= hostData_nxt;
            hostOe_r    <= hostOe_nxt;
        end
    end

    // =============================================================
    // Resets and infrared strap sampling.
    logic [CHANNELS-1:0] chanReset_r, chanReset_nxt;
    logic [CHANNELS-1:0] irLoad_r, irLoad_nxt;
    logic                irValue_r, irValue_nxt;
    logic [1:0]          strapWait_r, strapWait_nxt;

    always_comb begin
        // RULE7 channel reset output
        chanReset_nxt = swReset;
        strapWait_nxt = strapWait_r;
        irLoad_nxt    = '0;
        irValue_nxt   = irValue_r;
        // RULE10 strap sample and load
        if (strapWait_r != 2'd0) begin
            strapWait_nxt = strapWait_r - 2'd1;
            if (strapWait_r == 2'd1) begin
                irLoad_nxt  = '1;
                irValue_nxt = pins.strap;
            end
        end
        if (swReset != '0) begin
            irLoad_nxt  = irLoad_nxt | swReset;
            irValue_nxt = pins.strap;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            chanReset_r <= '1;
            irLoad_r    <= '0;
            irValue_r   <= 1'b0;
            strapWait_r <= STRAP_WAIT;
        end else begin
            chanReset_r <= chanReset_nxt;
            irLoad_r    <= irLoad_nxt;
            irValue_r   <= irValue_nxt;
            strapWait_r <= strapWait_nxt;
        end
    end

    // =============================================================
    // Serial side pins and timer clock.
    logic [CHANNELS-1:0] rxOut_r, rxOut_nxt;
    logic [CHANNELS-1:0] txPin_r, rtsN_r, dtrN_r;
    ouhcs_modem_type     modem_r, modem_nxt;
    logic                tmrPrev_r;
    logic                timerTick_r, timerTick_nxt;

    // RULE11 infrared receive inversion
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : gRx
        always_comb begin
            rxOut_nxt[ch] = pins.rx[ch] ^ (modemControlReg[ch][MCR_IR_BIT]
                                           & featureControlReg[ch][FEATURE_CONTROL_REG_IR_INV_BIT]);
        end
    end

    // RULE14 active low modem pins
    assign modem_nxt     = ~pins.modemN;
    // RULE13 external timer clock edge
    assign timerTick_nxt = pins.tmrClk && !tmrPrev_r;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            // RULE12 receive idles high
            rxOut_r     <= '1;
            txPin_r     <= '1;
            rtsN_r      <= '1;
            dtrN_r      <= '1;
            modem_r     <= '0;
            tmrPrev_r   <= 1'b0;
            timerTick_r <= 1'b0;
        end else begin
            rxOut_r     <= rxOut_nxt;
            txPin_r     <= txBit;
            rtsN_r      <= ~rtsReq;
            dtrN_r      <= ~dtrReq;
            modem_r     <= modem_nxt;
            tmrPrev_r   <= pins.tmrClk;
            timerTick_r <= timerTick_nxt;
        end
    end

    assign hostDataOut = hostData_r;
    assign hostDataOe  = hostOe_r;
    assign txPin       = txPin_r;
    assign rtsN        = rtsN_r;
    assign dtrN        = dtrN_r;
    assign rxToChan    = rxOut_r;
    assign modemIn     = modem_r;
    assign chanWrite   = chanWrite_r;
    assign chanRead    = chanRead_r;
    assign regSel      = regSel_r;
    assign writeData   = writeData_r;
    assign chanReset   = chanReset_r;
    assign irModeLoad  = irLoad_r;
    assign irModeValue = irValue_r;
    assign timerTick   = timerTick_r;
    assign broadcastEn = bcast_r[BCAST_EN_BIT];

    // =============================================================
    // Assertions.
    AST_CHAN_DECODE: assert property (@(posedge clock) disable iff (reset) // RULE3
        accStart && !accIsRead && !cfgSpace && !bcast_r[BCAST_EN_BIT]
        |=> chanWrite == (8'h01 << $past(chanNum)))
        else $error("Channel write not routed to decoded channel.");

    AST_BCAST_ALL: assert property (@(posedge clock) disable iff (reset) // RULE4
        accStart && !accIsRead && !cfgSpace && bcast_r[BCAST_EN_BIT]
        |=> chanWrite == 8'hFF)
        else $error("Broadcast write did not reach all channels.");

    AST_CFG_NO_CHAN: assert property (@(posedge clock) disable iff (reset) // RULE16
        accStart && cfgSpace |=> chanWrite == 8'h00 && chanRead == 8'h00)
        else $error("Configuration access reached a channel.");

    AST_STYLE_READ: assert property (@(posedge clock) disable iff (reset) // RULE1
        accStart && !pins.busStyle && pins.wrN && !cfgSpace
        |=> chanRead != 8'h00 && chanWrite == 8'h00)
        else $error("Alternative style read not decoded as read.");

    AST_SW_RESET: assert property (@(posedge clock) disable iff (reset) // RULE9
        accStart && !accIsRead && pins.addr == CFG_SW_RESET
        |=> chanReset == $past(pins.data) ##1 chanReset == 8'h00)
        else $error("Software reset did not reach designated channels.");

    AST_STRAP_LOAD: assert property (@(posedge clock) // RULE10
        $fell(reset) |-> irModeLoad == 8'h00 ##3 irModeLoad == 8'hFF
        ##1 irModeLoad == 8'h00)
        else $error("Strap not loaded after reset release.");

    AST_HW_RESET: assert property (@(posedge clock) // RULE7
        reset && $past(reset)
        |-> chanReset == 8'hFF && rtsN == 8'hFF && dtrN == 8'hFF && txPin == 8'hFF)
        else $error("Outputs not at defaults during reset.");

    AST_RX_INVERT: assert property (@(posedge clock) disable iff (reset) // RULE11
        modemControlReg[0][MCR_IR_BIT] && featureControlReg[0][FEATURE_CONTROL_REG_IR_INV_BIT]
        |=> rxToChan[0] == !$past(pins.rx[0]))
        else $error("Infrared receive not inverted.");

    AST_RX_IDLE: assert property (@(posedge clock) disable iff (reset) // RULE12
        !modemControlReg[0][MCR_IR_BIT] |=> rxToChan[0] == $past(pins.rx[0]))
        else $error("Normal receive altered.");

    AST_TIMER_TICK: assert property (@(posedge clock) disable iff (reset) // RULE13
        timerTick |=> !timerTick)
        else $error("Timer tick longer than one cycle.");

    AST_MODEM_POL: assert property (@(posedge clock) disable iff (reset) // RULE14
        ##1 modemIn.cts == ~$past(pins.modemN.cts))
        else $error("Modem input polarity wrong.");

    AST_INT_SRC: assert property (@(posedge clock) disable iff (reset) // RULE15
        accActive && accIsRead && pins.addr == CFG_INT_SRC0 |=> hostDataOut == $past(chanIntPend))
        else $error("Interrupt source read wrong.");

endmodule // ouhcs_top

// ===== tb/ouhcs_host.sv
// =============================================================
// Host CPU model driving the parallel bus pins.
module ouhcs_host
    import ouhcs_pkg::*;
(
    input  wire logic              clock, // System clock.
    input  wire logic [DATA_W-1:0] rdBus, // Read data.
    input  wire logic              rdOe,  // Device drives bus.
    output logic                   csN,   // Chip select.
    output logic                   rdN,   // Read strobe.
    output logic                   wrN,   // Write strobe or direction.
    output logic [ADDR_W-1:0]      addr,  // Address.
    output logic [DATA_W-1:0]      dout   // Write data.
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        {csN, rdN, wrN} = 3'b111;
        addr = 8'h00;
        dout = 8'h00;
    end

    task automatic access(input logic style, input logic wr, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q, output logic oe);
        @(posedge clock);
        csN  <= 1'b0;
        rdN  <= style ? wr : 1'b1;
        wrN  <= ~wr;
        addr <= a;
        dout <= wr ? d : ~dout;
        repeat (5) @(posedge clock);
        q  = rdBus;
        oe = rdOe;
        {csN, rdN, wrN} <= 3'b111;
        dout <= ~dout;
        repeat (4) @(posedge clock);
    endtask
endmodule // ouhcs_host

// ===== tb/octal_uart_host_channel_select_bench.sv
// =============================================================
// Bench for the host channel select front end.
module octal_uart_host_channel_select_bench
    import ouhcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic               clock, reset, busStyleSel, csN, readStrobeN, writeStrobeN, oe;
    logic               hostDataOe, infraredStartupStrap, timerExtClk, timerIntPend;
    logic               wakeIntPend, irModeValue, timerTick, broadcastEn;
    logic [7:0]         addrPin, dataPin, hostDataOut, rxPin, ctsN, dsrN, cdN, riN, txBit;
    logic [7:0]         rtsReq, dtrReq, chanIntPend, txPin, rtsN, dtrN, rxToChan, chanWrite;
    logic [7:0]         chanRead, writeData, chanReset, irModeLoad, q, m, f;
    logic [7:0]         wrSeen, wrData, rdSeen, rstSeen, irSeen;
    logic [7:0]         expTab [4];
    logic [3:0]         regSel, wrSel;
    ouhcs_byte_arr_type modemControlReg, featureControlReg, chanReadData;
    ouhcs_code_arr_type chanIntCode;
    ouhcs_modem_type    modemIn;
    int                 seed, num_errors, n_checks, ticks, cycles;

    ouhcs_host i_host (.clock(clock), .rdBus(hostDataOut), .rdOe(hostDataOe), .csN(csN),
        .rdN(readStrobeN), .wrN(writeStrobeN), .addr(addrPin), .dout(dataPin));

    ouhcs_top i_dut (.clock(clock), .reset(reset), .busStyleSel(busStyleSel), .csN(csN),
        .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .addrPin(addrPin),
        .dataPin(dataPin), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
        .infraredStartupStrap(infraredStartupStrap), .timerExtClk(timerExtClk),
        .rxPin(rxPin), .ctsN(ctsN), .dsrN(dsrN), .cdN(cdN), .riN(riN), .txBit(txBit),
        .rtsReq(rtsReq), .dtrReq(dtrReq), .modemControlReg(modemControlReg),
        .featureControlReg(featureControlReg), .chanReadData(chanReadData),
        .chanIntPend(chanIntPend), .chanIntCode(chanIntCode), .timerIntPend(timerIntPend),
        .wakeIntPend(wakeIntPend), .txPin(txPin), .rtsN(rtsN), .dtrN(dtrN),
        .rxToChan(rxToChan), .modemIn(modemIn), .chanWrite(chanWrite), .chanRead(chanRead),
        .regSel(regSel), .writeData(writeData), .chanReset(chanReset),
        .irModeLoad(irModeLoad), .irModeValue(irModeValue), .timerTick(timerTick),
        .broadcastEn(broadcastEn));

    always #5 clock = ~clock;

    // Pulses are gathered between accesses so one check sees the whole access.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            summarize();
        end
        if (!reset) begin
            wrSeen  <= wrSeen | chanWrite;
            rdSeen  <= rdSeen | chanRead;
            rstSeen <= rstSeen | chanReset;
            irSeen  <= irSeen | irModeLoad;
            ticks   <= ticks + int'(timerTick);
            if (chanWrite != 8'h00) begin
                wrSel  <= regSel;
                wrData <= writeData;
            end
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        {wrSeen, rdSeen, rstSeen, irSeen} = '0;
        i_host.access(busStyleSel, wr, a, d, q, oe);
    endtask

    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        seed = 87951;
        clock = 1'b0;
        {reset, busStyleSel, infraredStartupStrap, timerExtClk, timerIntPend} = 5'b11100;
        {wakeIntPend, rxPin, ctsN, dsrN, cdN, riN} = {1'b0, 40'hFF_FFFF_FFFF};
        {txBit, rtsReq, dtrReq, chanIntPend, wrSeen, rdSeen, rstSeen, irSeen} = '0;
        {modemControlReg, featureControlReg, chanIntCode} = '0;
        chanReadData = {$random(seed), $random(seed)};
        repeat (2) @(posedge clock);
        #1;
        chk(txPin, 8'hFF);
        chk(chanReset, 8'hFF);
        @(posedge clock);
        reset <= 1'b0;
        repeat (5) @(posedge clock);
        chk(irSeen, 8'hFF);
        chk({7'h00, irModeValue}, 8'h01);
        for (int i = 0; i < 16; i++) begin
            if (i == 8) begin
                busStyleSel <= 1'b0;
                repeat (3) @(posedge clock);
            end
            m = 8'($random(seed));
            bus(1'b1, {1'b0, 3'(i), m[3:0]}, m ^ 8'h3C);
            chk(wrSeen, 8'h01 << i[2:0]);
            chk({4'h0, wrSel}, {4'h0, m[3:0]});
            chk(wrData, m ^ 8'h3C);
            bus(1'b0, {1'b0, 3'(i), m[3:0]}, 8'h00);
            chk(rdSeen, 8'h01 << i[2:0]);
            chk(q, chanReadData[i[2:0]]);
            chk({7'h00, oe}, 8'h01);
        end
        bus(1'b1, CFG_BCAST, 8'h01);
        chk({7'h00, broadcastEn}, 8'h01);
        chk(wrSeen, 8'h00);
        bus(1'b1, 8'h35, 8'hA5);
        chk(wrSeen, 8'hFF);
        bus(1'b0, CFG_BCAST, 8'h00);
        chk(q, 8'h01);
        bus(1'b1, CFG_BCAST, 8'h00);
        chk({7'h00, broadcastEn}, 8'h00);
        {chanIntPend, chanIntCode, timerIntPend, wakeIntPend} <= 26'($random(seed));
        @(negedge clock);
        expTab = '{chanIntPend, chanIntCode[3:0], chanIntCode[7:4],
                   {6'h00, wakeIntPend, timerIntPend}};
        for (int k = 0; k < 4; k++) begin
            bus(1'b0, CFG_INT_SRC0 + 8'(k), 8'h00);
            chk(q, expTab[k]);
        end
        bus(1'b0, 8'h9C, 8'h00);
        chk(q, 8'h00);
        infraredStartupStrap <= 1'b0;
        bus(1'b1, CFG_SW_RESET, 8'h5A);
        chk(rstSeen, 8'h5A);
        chk(irSeen, 8'h5A);
        chk({7'h00, irModeValue}, 8'h00);
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            {txBit, rtsReq, dtrReq, rxPin} <= $random(seed);
            {ctsN, dsrN, cdN, riN} <= $random(seed);
            m = 8'($random(seed)) | 8'(k == 0);
            f = 8'($random(seed)) | 8'(k == 0);
            for (int j = 0; j < 8; j++) begin
                modemControlReg[j] <= {1'b0, m[j], 6'h00};
                featureControlReg[j] <= {3'h0, f[j], 4'h0};
            end
            repeat (4) @(posedge clock);
            #1;
            chk(rtsN, ~rtsReq);
            chk(dtrN, ~dtrReq);
            chk(txPin, txBit);
            chk(rxToChan, rxPin ^ (m & f));
            chk(modemIn.cts, ~ctsN);
            chk(modemIn.dsr ^ modemIn.cd ^ modemIn.ri, ~(dsrN ^ cdN ^ riN));
        end
        for (int k = 0; k < 6; k++) begin
            @(posedge clock);
            timerExtClk <= 1'b1;
            repeat (3) @(posedge clock);
            timerExtClk <= 1'b0;
            repeat (2) @(posedge clock);
        end
        repeat (4) @(posedge clock);
        chk(8'(ticks), 8'h06);
        bus(1'b1, CFG_BCAST, 8'h01);
        reset <= 1'b1;
        rtsReq <= 8'hFF;
        repeat (5) @(posedge clock);
        #1;
        chk(rtsN & txPin & chanReset, 8'hFF);
        chk({7'h00, broadcastEn}, 8'h00);
        summarize();
    end
endmodule // octal_uart_host_channel_select_bench
